// file: verilog/pmcb_pkg.sv
// command codes, reset values, link framing and storage layout of the command bank
package pmcb_pkg;
    // command codes
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
    localparam logic [7:0] CMD_OEM_A = 8'hB0;
    localparam logic [7:0] CMD_TOOL = 8'hB1;
    localparam logic [7:0] CMD_OEM_B = 8'hB2;
    localparam logic [7:0] CMD_USER_PG = 8'hB3;
    localparam logic [7:0] CMD_USER_SH = 8'hB4;
    localparam logic [7:0] CMD_INFO = 8'hB6;
    localparam logic [7:0] CMD_EE_UNLOCK = 8'hBD;
    localparam logic [7:0] CMD_EE_ERASE = 8'hBE;
    localparam logic [7:0] CMD_EE_DATA = 8'hBF;
    localparam logic [7:0] CMD_CHAN_CFG = 8'hD0;
    localparam logic [7:0] CMD_GLOB_CFG = 8'hD1;
    localparam logic [7:0] CMD_GPIO_MASK = 8'hD2;
    localparam logic [7:0] CMD_PWM_CFG = 8'hD4;
    localparam logic [7:0] CMD_GPIO_ACT = 8'hD5;
    localparam logic [7:0] CMD_OT_ACT = 8'hD6;
    localparam logic [7:0] CMD_IOUT_PK = 8'hD7;
    localparam logic [7:0] CMD_ADC_SEL = 8'hD8;
    localparam logic [7:0] CMD_ADC_LAST = 8'hDA;
    localparam logic [7:0] CMD_RETRY = 8'hDB;
    localparam logic [7:0] CMD_HOLD = 8'hDC;
    localparam logic [7:0] CMD_VOUT_PK = 8'hDD;
    localparam logic [7:0] CMD_VIN_PK = 8'hDE;
    localparam logic [7:0] CMD_TEMP_PK = 8'hDF;
    localparam logic [7:0] CMD_CLR_PK = 8'hE3;
    localparam logic [7:0] CMD_PADS = 8'hE5;
    localparam logic [7:0] CMD_ADDR = 8'hE6;
    // values after reset, fixed overtemperature action, erased and empty-read words
    localparam logic [15:0] DEF_WORD = 16'h0000;
    localparam logic [7:0] DEF_CHAN_CFG = 8'h1D;
    localparam logic [7:0] DEF_GLOB_CFG = 8'h21;
    localparam logic [15:0] DEF_GPIO_MASK = 16'h6993;
    localparam logic [7:0] DEF_PWM_CFG = 8'hC1;
    localparam logic [7:0] DEF_GPIO_ACT = 8'hC0;
    localparam logic [7:0] OT_ACTION_VAL = 8'hC0;
    localparam logic [7:0] DEF_ADC_SEL = 8'h00;
    localparam logic [15:0] DEF_RETRY = 16'hFABC;
    localparam logic [15:0] DEF_HOLD = 16'hFBE8;
    localparam logic [6:0] DEF_ADDR = 7'h4F;
    localparam logic [15:0] EE_BLANK = 16'hFFFF;
    localparam logic [15:0] EMPTY_READ = 16'h0000;
    // telemetry kinds
    localparam logic [1:0] KIND_IOUT = 2'h0;
    localparam logic [1:0] KIND_VOUT = 2'h1;
    localparam logic [1:0] KIND_VIN = 2'h2;
    localparam logic [1:0] KIND_TEMP = 2'h3;
    // link framing, counted in link clock edges from frame start, and bytes taken per frame
    localparam logic [5:0] LNK_TURN = 6'h10;
    localparam logic [5:0] LNK_RD_LAST = 6'h20;
    localparam logic [5:0] LNK_CNT_MAX = 6'h3F;
    localparam logic [2:0] MAX_BYTES = 3'h4;
    // millisecond timebase
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 8;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
    // non-volatile image, copied whole by store-all and restore-all
    typedef struct packed {
        logic [15:0] oemA;
        logic [1:0][15:0] toolPg;
        logic [15:0] oemB;
        logic [1:0][15:0] userPg;
        logic [15:0] userSh;
        logic [1:0][7:0] chanCfg;
        logic [7:0] globCfg;
        logic [1:0][15:0] gpioMask;
        logic [1:0][7:0] pwmCfg;
        logic [1:0][7:0] gpioAct;
        logic [7:0] adcLast;
        logic [1:0][15:0] retryIv;
        logic [1:0][15:0] holdIv;
        logic [6:0] busAddr;
    } pmcb_nvm_t;
    localparam pmcb_nvm_t NVM_DEFAULT = '{oemA: DEF_WORD, toolPg: {DEF_WORD, DEF_WORD},
        oemB: DEF_WORD, userPg: {DEF_WORD, DEF_WORD}, userSh: DEF_WORD,
        chanCfg: {DEF_CHAN_CFG, DEF_CHAN_CFG}, globCfg: DEF_GLOB_CFG,
        gpioMask: {DEF_GPIO_MASK, DEF_GPIO_MASK}, pwmCfg: {DEF_PWM_CFG, DEF_PWM_CFG},
        gpioAct: {DEF_GPIO_ACT, DEF_GPIO_ACT}, adcLast: DEF_ADC_SEL,
        retryIv: {DEF_RETRY, DEF_RETRY}, holdIv: {DEF_HOLD, DEF_HOLD}, busAddr: DEF_ADDR};
endpackage

// file: verilog/pmcb_bank.sv
// command register bank with serial link front end, peak trackers and timers
//
// Summary of operation
// R1 - per-page and shared user words, non-volatile, reset to zero
// R2 - two shared non-volatile maker words for serial numbers
// R3 - erase and data commands refused until unlock written
// R4 - erase command blanks the whole user store for bulk programming
// R5 - data command moves one word, pointer advances each access
// R6 - per-page output current peak, exponent-mantissa format
// R7 - per-page output voltage peak, unsigned fixed-exponent format
// R8 - single input voltage peak, exponent-mantissa format
// R9 - per-page external temperature peak, exponent-mantissa format
// R10 - clear-peaks command restarts every peak tracker
// R11 - answer only at programmable 7-bit address, default 0x4F
// R12 - hold channel enable low for programmed milliseconds after turn-off
// R13 - wait programmed milliseconds between retry attempts
// R14 - select one telemetry kind for fast conversion, default zero
// R15 - report most recently converted kind while short loop runs
// R16 - external low on GPIO triggers per-page configured action
// R17 - overtemperature fault triggers fixed action 0xC0
// R18 - drive GPIO only for faults enabled in per-page mask
// R19 - per-page channel configuration byte, default 0x1D
// R20 - shared configuration byte, page independent, default 0x21
// R21 - per-page PWM engine configuration byte, default 0xC1
// R22 - read-only word shows current pad levels
// R23 - exponent in bits 15..11, mantissa in 10..0, both signed
// R24 - unsigned mantissa with fixed exponent minus twelve
// R25 - store-all saves and restore-all reloads non-volatile commands
// R26 - new conversion replaces stored peak when larger
`timescale 1ns/1ps
module pmcb_bank
    import pmcb_pkg::*;
#(
    parameter int EE_DEPTH = 64,
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter logic [15:0] INFO_WORD = 16'h0000 // arbitrary value
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic lnkClk,
    input wire logic lnkFrame,
    input wire logic lnkDin,
    output logic lnkDoutO,
    output logic lnkDoutOe,
    input wire logic adcValid,
    input wire logic [1:0] adcKind,
    input wire logic adcPage,
    input wire logic [15:0] adcData,
    input wire logic shortLoopOn,
    input wire logic [1:0] chanOff,
    input wire logic [1:0] retryReq,
    input wire logic [1:0][15:0] faultBits,
    input wire logic [1:0] gpioIn,
    output logic [1:0] gpioO,
    output logic [1:0] gpioOe,
    input wire logic otFault,
    input wire logic [15:0] padIn,
    output logic [1:0] enHoldLow,
    output logic [1:0] retryGo,
    output logic [1:0][7:0] gpioLowAct,
    output logic [7:0] otAction,
    output logic [7:0] fastAdcSel,
    output logic [1:0][7:0] chanCfg,
    output logic [7:0] globalCfg,
    output logic [1:0][7:0] pwmCfg,
    output logic [6:0] busAddr
);
    localparam int AW = $clog2(EE_DEPTH);
    localparam int MSW = $clog2(MS_CYCLES);
    localparam int ERASE_MAX = EE_DEPTH + 2;

    // pointer and erase index wrap at the array end, so the depth must be a power of two
    if (EE_DEPTH < 2 || EE_DEPTH > 256 || (EE_DEPTH & (EE_DEPTH - 1)) != 0 || MS_CYCLES < 2)
    begin : g_bad
        $error("pmcb_bank: EE_DEPTH must be a power of two 2..256, MS_CYCLES at least 2");
    end

    typedef struct packed {
        pmcb_nvm_t nvm;
        pmcb_nvm_t shadow;
        logic page;
        logic frmS1, frmS2, frmPrev, togS1, togS2, togPrev;
        logic [2:0] nBytes;
        logic [3:0][7:0] rx;
        logic rdGo;
        logic [15:0] readWord;
        logic unlocked;
        logic [AW-1:0] eePtr;
        logic eraseBusy;
        logic [AW-1:0] eraseIdx;
        logic [3:0][1:0][15:0] peak;
        logic [3:0][1:0] peakOk;
        logic [7:0] adcSel;
        logic [MSW-1:0] msCnt;
        logic [1:0][16:0] holdCnt;
        logic [1:0][16:0] retryCnt;
        logic [1:0] retryArm;
        logic [1:0] retryGo;
        logic [1:0] gS1, gS2, gpioDrv;
        logic [1:0][7:0] gpioLowAct;
        logic [7:0] otAct;
        logic [15:0] padS1, padS2;
    } pmcb_sys_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic [7:0] sh;
        logic [7:0] hold;
        logic [15:0] outSh;
        logic oe;
    } pmcb_lnk_t;

    localparam pmcb_sys_t SYS_RESET = '{nvm: NVM_DEFAULT, shadow: NVM_DEFAULT,
        adcSel: DEF_ADC_SEL, gS1: 2'h3, gS2: 2'h3, default: '0};

    // value of an exponent-mantissa word as fixed point with 16 fraction bits
    function automatic logic signed [47:0] l11Fix(input logic [15:0] w);
        logic signed [47:0] m;
        logic [5:0] sh;
        m = 48'(signed'(w[10:0]));
        sh = 6'(signed'(w[15:11]) + 16);
        return m <<< sh; // R23
    endfunction

    // whole milliseconds of a non-negative exponent-mantissa word, rounded up
    function automatic logic [15:0] l11Ms(input logic [15:0] w);
        logic [31:0] m;
        logic [31:0] v;
        logic [4:0] sh;
        m = w[10] ? 32'h0 : {21'h0, w[10:0]};
        sh = w[15] ? 5'(-w[15:11]) : w[15:11];
        v = w[15] ? ((m + (32'h1 << sh) - 32'h1) >> sh) : (m << sh); // R23
        return (v > 32'h0000FFFF) ? 16'hFFFF : v[15:0];
    endfunction

    pmcb_sys_t r, n;
    pmcb_lnk_t l, ln;
    logic lnkTog, lnkRst, byteDone;
    logic [15:0] eeMem [EE_DEPTH];
    logic memWe, clrPk, eeWe, eraseStart, msTick;
    logic [AW-1:0] memAddr;
    logic [15:0] memWd, rd, wData;
    logic [7:0] cmd;
    logic [1:0] pk;
    logic pp, larger;

    // link side: shift in on every rising edge, hand whole bytes over by toggle
    assign lnkRst = sys_rst | ~lnkFrame;
    assign byteDone = (l.cnt[2:0] == 3'h7) && (l.cnt < LNK_RD_LAST);
    always_comb
    begin
        ln = l;
        ln.sh = {l.sh[6:0], lnkDin};
        if (l.cnt != LNK_CNT_MAX)
            ln.cnt = l.cnt + 6'h1;
        if (byteDone)
            ln.hold = {l.sh[6:0], lnkDin};
        // readWord and rdGo settle well before this edge, so they are quasi-static here
        if (l.cnt == LNK_TURN)
        begin
            ln.outSh = {r.readWord[7:0], r.readWord[15:8]};
            ln.oe = r.rdGo;
        end
        else if (l.oe)
        begin
            if (l.cnt == LNK_RD_LAST)
                ln.oe = 1'b0;
            else
                ln.outSh = {l.outSh[14:0], 1'b0};
        end
    end

    // the frame signal clears the link side, the clock stops between frames
    always_ff @(posedge lnkClk or posedge lnkRst)
    begin
        if (lnkRst)
            l <= '0;
        else
            l <= ln;
    end

    // toggle survives frame end so that no byte event is faked
    always_ff @(posedge lnkClk or posedge sys_rst)
    begin
        if (sys_rst)
            lnkTog <= 1'b0;
        else
            lnkTog <= lnkTog ^ byteDone;
    end

    assign lnkDoutO = l.outSh[15];
    assign lnkDoutOe = l.oe;

    // system side: decode, commit, trackers and timers
    always_comb
    begin
        n = r;
        memWe = 1'b0;
        memAddr = r.eePtr;
        memWd = EE_BLANK;
        clrPk = 1'b0;
        eeWe = 1'b0;
        eraseStart = 1'b0;
        rd = EMPTY_READ;
        cmd = l.hold;
        wData = {r.rx[3], r.rx[2]};
        pk = adcKind;
        pp = (adcKind == KIND_VIN) ? 1'b0 : adcPage;
        larger = 1'b0;
        n.frmS1 = lnkFrame;
        n.frmS2 = r.frmS1;
        n.frmPrev = r.frmS2;
        n.togS1 = lnkTog;
        n.togS2 = r.togS1;
        n.togPrev = r.togS2;
        n.gS1 = gpioIn;
        n.gS2 = r.gS1;
        n.padS1 = padIn;
        n.padS2 = r.padS1;
        n.retryGo = 2'h0;
        // read data is chosen as soon as the command byte lands
        unique case (cmd)
            CMD_PAGE: rd = {15'h0, r.page};
            CMD_OEM_A: rd = r.nvm.oemA; // R2
            CMD_TOOL: rd = r.nvm.toolPg[r.page];
            CMD_OEM_B: rd = r.nvm.oemB; // R2
            CMD_USER_PG: rd = r.nvm.userPg[r.page]; // R1
            CMD_USER_SH: rd = r.nvm.userSh; // R1
            CMD_INFO: rd = INFO_WORD;
            CMD_EE_UNLOCK: rd = {15'h0, r.unlocked};
            CMD_EE_ERASE: rd = {15'h0, r.eraseBusy};
            CMD_EE_DATA: rd = (r.unlocked && !r.eraseBusy) ? eeMem[r.eePtr] : EMPTY_READ; // R3
            CMD_CHAN_CFG: rd = {8'h0, r.nvm.chanCfg[r.page]}; // R19
            CMD_GLOB_CFG: rd = {8'h0, r.nvm.globCfg}; // R20
            CMD_GPIO_MASK: rd = r.nvm.gpioMask[r.page];
            CMD_PWM_CFG: rd = {8'h0, r.nvm.pwmCfg[r.page]}; // R21
            CMD_GPIO_ACT: rd = {8'h0, r.nvm.gpioAct[r.page]};
            CMD_OT_ACT: rd = {8'h0, OT_ACTION_VAL}; // R17
            CMD_ADC_SEL: rd = {8'h0, r.adcSel};
            CMD_ADC_LAST: rd = {8'h0, r.nvm.adcLast};
            CMD_RETRY: rd = r.nvm.retryIv[r.page];
            CMD_HOLD: rd = r.nvm.holdIv[r.page];
            CMD_IOUT_PK: rd = r.peakOk[KIND_IOUT][r.page] ? r.peak[KIND_IOUT][r.page] : EMPTY_READ; // R6
            CMD_VOUT_PK: rd = r.peakOk[KIND_VOUT][r.page] ? r.peak[KIND_VOUT][r.page] : EMPTY_READ; // R7
            CMD_VIN_PK: rd = r.peakOk[KIND_VIN][0] ? r.peak[KIND_VIN][0] : EMPTY_READ; // R8
            CMD_TEMP_PK: rd = r.peakOk[KIND_TEMP][r.page] ? r.peak[KIND_TEMP][r.page] : EMPTY_READ; // R9
            CMD_PADS: rd = r.padS2; // R22
            CMD_ADDR: rd = {9'h0, r.nvm.busAddr};
            default: rd = EMPTY_READ;
        endcase
        // collect link bytes: address, command, then data low and high
        if ((r.togS2 != r.togPrev) && (r.nBytes != MAX_BYTES))
        begin
            n.rx[r.nBytes[1:0]] = l.hold;
            n.nBytes = r.nBytes + 3'h1;
            if (r.nBytes == 3'h1)
            begin
                n.rdGo = r.rx[0][0] && (r.rx[0][7:1] == r.nvm.busAddr); // R11
                n.readWord = rd;
                if (n.rdGo && cmd == CMD_EE_DATA && r.unlocked && !r.eraseBusy)
                    n.eePtr = r.eePtr + AW'(1); // R5
            end
        end
        // writes take effect when the frame closes
        if (r.frmPrev && !r.frmS2)
        begin
            n.nBytes = 3'h0;
            n.rdGo = 1'b0;
            if (!r.rx[0][0] && (r.rx[0][7:1] == r.nvm.busAddr) && r.nBytes >= 3'h2) // R11
            begin
                if (r.nBytes == 3'h2)
                begin
                    clrPk = (r.rx[1] == CMD_CLR_PK); // R10
                    if (r.rx[1] == CMD_STORE_ALL)
                        n.shadow = r.nvm; // R25
                    if (r.rx[1] == CMD_RESTORE_ALL)
                        n.nvm = r.shadow; // R25
                end
                else if (r.nBytes == 3'h3)
                begin
                    unique case (r.rx[1])
                        CMD_PAGE: n.page = r.rx[2][0];
                        CMD_CHAN_CFG: n.nvm.chanCfg[r.page] = r.rx[2]; // R19
                        CMD_GLOB_CFG: n.nvm.globCfg = r.rx[2]; // R20
                        CMD_PWM_CFG: n.nvm.pwmCfg[r.page] = r.rx[2]; // R21
                        CMD_GPIO_ACT: n.nvm.gpioAct[r.page] = r.rx[2]; // R16
                        CMD_ADC_SEL: n.adcSel = r.rx[2]; // R14
                        CMD_ADC_LAST: n.nvm.adcLast = r.rx[2];
                        CMD_ADDR: n.nvm.busAddr = r.rx[2][6:0]; // R11
                        CMD_EE_UNLOCK:
                        begin
                            n.unlocked = (r.rx[2] != 8'h00); // R3
                            n.eePtr = '0;
                        end
                        CMD_EE_ERASE: eraseStart = r.unlocked && !r.eraseBusy; // R3
                        default: n.page = r.page;
                    endcase
                end
                else
                begin
                    unique case (r.rx[1])
                        CMD_OEM_A: n.nvm.oemA = wData; // R2
                        CMD_TOOL: n.nvm.toolPg[r.page] = wData;
                        CMD_OEM_B: n.nvm.oemB = wData; // R2
                        CMD_USER_PG: n.nvm.userPg[r.page] = wData; // R1
                        CMD_USER_SH: n.nvm.userSh = wData; // R1
                        CMD_GPIO_MASK: n.nvm.gpioMask[r.page] = wData; // R18
                        CMD_RETRY: n.nvm.retryIv[r.page] = wData; // R13
                        CMD_HOLD: n.nvm.holdIv[r.page] = wData; // R12
                        CMD_EE_DATA: eeWe = r.unlocked && !r.eraseBusy; // R3
                        default: n.page = r.page;
                    endcase
                end
            end
        end
        // one word per data write, pointer walks on
        if (eeWe)
        begin
            memWe = 1'b1;
            memWd = wData;
            n.eePtr = r.eePtr + AW'(1); // R5
        end
        // erase blanks one location per cycle; data access is refused meanwhile
        if (eraseStart)
        begin
            n.eraseBusy = 1'b1;
            n.eraseIdx = '0;
            n.eePtr = '0;
        end
        else if (r.eraseBusy)
        begin
            memWe = 1'b1;
            memAddr = r.eraseIdx;
            n.eraseIdx = r.eraseIdx + AW'(1);
            if (r.eraseIdx == AW'(EE_DEPTH - 1))
                n.eraseBusy = 1'b0; // R4
        end
        // clear first, so a conversion in the same cycle seeds the new peak
        if (clrPk)
            n.peakOk = '0; // R10
        if (adcValid)
        begin
            larger = (pk == KIND_VOUT) ? (adcData > r.peak[pk][pp]) // R24
                : (l11Fix(adcData) > l11Fix(r.peak[pk][pp]));
            if (!n.peakOk[pk][pp] || larger)
            begin
                n.peak[pk][pp] = adcData; // R26
                n.peakOk[pk][pp] = 1'b1;
            end
            if (shortLoopOn)
                n.nvm.adcLast = {6'h0, adcKind}; // R15
        end
        // free running millisecond tick; loads add one tick so the time is a minimum
        msTick = (r.msCnt == MSW'(MS_CYCLES - 1));
        n.msCnt = msTick ? '0 : r.msCnt + MSW'(1);
        for (int c = 0; c < 2; c++)
        begin
            if (chanOff[c])
                n.holdCnt[c] = {1'b0, l11Ms(r.nvm.holdIv[c])} + 17'h1; // R12
            else if (msTick && r.holdCnt[c] != 17'h0)
                n.holdCnt[c] = r.holdCnt[c] - 17'h1;
            if (retryReq[c])
            begin
                n.retryCnt[c] = {1'b0, l11Ms(r.nvm.retryIv[c])} + 17'h1; // R13
                n.retryArm[c] = 1'b1;
            end
            else if (r.retryArm[c] && r.retryCnt[c] == 17'h0)
            begin
                n.retryGo[c] = 1'b1; // R13
                n.retryArm[c] = 1'b0;
            end
            else if (msTick && r.retryCnt[c] != 17'h0)
                n.retryCnt[c] = r.retryCnt[c] - 17'h1;
            n.gpioDrv[c] = |(faultBits[c] & r.nvm.gpioMask[c]); // R18
            n.gpioLowAct[c] = (!r.gS2[c] && !r.gpioDrv[c]) ? r.nvm.gpioAct[c] : 8'h00; // R16
        end
        n.otAct = otFault ? OT_ACTION_VAL : 8'h00; // R17
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            r <= SYS_RESET;
        else
            r <= n;
    end

    // user store keeps its contents through reset, as a real array would
    always_ff @(posedge clk)
    begin
        if (memWe)
            eeMem[memAddr] <= memWd;
    end

    assign gpioO = 2'h0;
    assign gpioOe = r.gpioDrv;
    assign gpioLowAct = r.gpioLowAct;
    assign otAction = r.otAct;
    assign enHoldLow[0] = (r.holdCnt[0] != 17'h0);
    assign enHoldLow[1] = (r.holdCnt[1] != 17'h0);
    assign retryGo = r.retryGo;
    assign fastAdcSel = r.adcSel;
    assign chanCfg = r.nvm.chanCfg;
    assign globalCfg = r.nvm.globCfg;
    assign pwmCfg = r.nvm.pwmCfg;
    assign busAddr = r.nvm.busAddr;

    // checks on the system clock
    sequence s_erase_go;
        eraseStart ##1 r.eraseBusy;
    endsequence
    property p_erase_done;
        @(posedge clk) disable iff (sys_rst) s_erase_go |-> ##[1:ERASE_MAX] !r.eraseBusy;
    endproperty
    a_erase_done: assert property (p_erase_done) else $error("erase never finished"); // R4
    property p_locked_refuse;
        @(posedge clk) disable iff (sys_rst) memWe && !r.eraseBusy |-> r.unlocked;
    endproperty
    a_locked_refuse: assert property (p_locked_refuse) else $error("store written while locked"); // R3
    property p_ee_advance;
        @(posedge clk) disable iff (sys_rst) eeWe |=> r.eePtr == $past(r.eePtr) + AW'(1);
    endproperty
    a_ee_advance: assert property (p_ee_advance) else $error("store pointer did not advance"); // R5
    property p_peak_clear;
        @(posedge clk) disable iff (sys_rst) clrPk && !adcValid |=> r.peakOk == '0;
    endproperty
    a_peak_clear: assert property (p_peak_clear) else $error("peaks not cleared"); // R10
    property p_peak_vout;
        @(posedge clk) disable iff (sys_rst)
            adcValid && adcKind == KIND_VOUT && adcData > r.peak[KIND_VOUT][adcPage]
            |=> r.peak[KIND_VOUT][$past(adcPage)] == $past(adcData);
    endproperty
    a_peak_vout: assert property (p_peak_vout) else $error("larger voltage not kept"); // R26
    property p_ot_action;
        @(posedge clk) disable iff (sys_rst) otFault |=> otAction == OT_ACTION_VAL;
    endproperty
    a_ot_action: assert property (p_ot_action) else $error("overtemperature action wrong"); // R17
    property p_gpio_mask;
        @(posedge clk) disable iff (sys_rst) |(faultBits[0] & r.nvm.gpioMask[0]) |=> gpioOe[0];
    endproperty
    a_gpio_mask: assert property (p_gpio_mask) else $error("masked fault not driven"); // R18
    sequence s_off_hold;
        chanOff[0] ##1 enHoldLow[0];
    endsequence
    property p_hold_low;
        @(posedge clk) disable iff (sys_rst) s_off_hold |-> enHoldLow[0] [*2];
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("enable hold released early"); // R12
    property p_retry_wait;
        @(posedge clk) disable iff (sys_rst) retryReq[0] |=> !retryGo[0] [*2];
    endproperty
    a_retry_wait: assert property (p_retry_wait) else $error("retry came too soon"); // R13
    property p_adc_last;
        @(posedge clk) disable iff (sys_rst)
            adcValid && shortLoopOn |=> r.nvm.adcLast[1:0] == $past(adcKind);
    endproperty
    a_adc_last: assert property (p_adc_last) else $error("last kind not reported"); // R15
endmodule

// file: verif/pmcb_host_model.sv
// host link model: framed transfers with the link clock running only inside frames
`timescale 1ns/1ps
module pmcb_host_model(
    output logic lnkClk = 1'h0,
    output logic lnkFrame = 1'h0,
    output logic lnkDin = 1'h0,
    input wire logic lnkDoutO
);
    // one command per frame; a released data line toggles so a stale bit never passes
    task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d,
        input int nb, output logic [15:0] rd);
        logic [31:0] sh;
        sh = {a, c, d[7:0], d[15:8]};
        lnkFrame = 1'h1;
        for (int k = 0; k < (a[0] ? 33 : nb * 8); k++)
        begin
            #40 lnkDin = (k < 16 || !a[0]) ? sh[31 - k] : ~lnkDin;
            #40 if (k > 16) rd[(k < 25 ? 24 : 40) - k] = lnkDoutO;
            lnkClk = 1'h1;
            #80 lnkClk = 1'h0;
        end
        #80 lnkFrame = 1'h0;
        #200 lnkDin = ~lnkDin;
    endtask
endmodule

// file: verif/pmcb_bank_tb_top.sv
// self-checking bench: register reads against a reference copy, peaks, store, timer
`timescale 1ns/1ps
module pmcb_bank_tb_top;
    logic clk = 1'h0, sys_rst = 1'h1, adcValid = 1'h0, otFault = 1'h0;
    logic [1:0] adcKind = 2'h0, chanOff = 2'h0, retryReq = 2'h0, enHoldLow, retryGo, gpioOe;
    logic [1:0][15:0] faultBits = 32'h0;
    logic [15:0] adcData = 16'h0, padIn = 16'h0, rd, m = 16'h0;
    logic [7:0] adr = 8'h9E, otAction;
    logic [15:0] expv [logic [7:0]];
    logic [15:0] pv [$] = {16'hD100, 16'hD380, 16'hD200};
    wire lnkClk, lnkFrame, lnkDin, lnkDoutO;
    int err_total = 0, samples_checked = 0, seed = 32'h9915, n = 0;
    pmcb_host_model host(.lnkClk, .lnkFrame, .lnkDin, .lnkDoutO);
    pmcb_bank #(.MS_CYCLES(10)) DUT(.clk, .sys_rst, .lnkClk, .lnkFrame, .lnkDin, .lnkDoutO,
        .lnkDoutOe(), .adcValid, .adcKind, .adcPage(1'h0), .adcData, .shortLoopOn(1'h1),
        .chanOff, .retryReq, .faultBits, .gpioIn(2'h3), .gpioO(), .gpioOe,
        .otFault, .padIn, .enHoldLow, .retryGo, .gpioLowAct(), .otAction, .fastAdcSel(),
        .chanCfg(), .globalCfg(), .pwmCfg(), .busAddr());
    // word commands move four bytes, byte commands three; writes update the reference
    function automatic bit isw(input logic [7:0] c);
        return c inside {8'hB3, 8'hB4, 8'hBF, 8'hD2, 8'hDB, 8'hDC, 8'hDD, 8'hE5};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        err_total += int'(got !== want);
        if (got !== want) $display("unexpected at %0t: got %h want %h", $time, got, want);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.xfer(adr, c, d, isw(c) ? 4 : 3, rd);
        expv[c] = isw(c) ? d : {8'h0, d[7:0]};
    endtask
    task automatic rdx(input logic [7:0] c, input logic [15:0] want);
        host.xfer(adr | 8'h1, c, 16'h0, 2, rd);
        chk(isw(c) ? rd : {8'h0, rd[7:0]}, want);
    endtask
    // prints the counts and the verdict, then ends the run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always #4 clk = ~clk; // 125 MHz
    // main sequence; expectations come from the reference copy and the queue
    initial
    begin
        expv = '{8'hB3: 16'h0, 8'hB4: 16'h0, 8'hD0: 16'h1D, 8'hD1: 16'h21, 8'hD2: 16'h6993,
            8'hD4: 16'hC1, 8'hD5: 16'hC0, 8'hD6: 16'hC0, 8'hD8: 16'h0, 8'hDB: 16'hFABC};
        #40 sys_rst = 1'h0;
        repeat (3) @(negedge clk);
        foreach (expv[c]) rdx(c, expv[c]);
        foreach (expv[c]) if (c != 8'hD6) wr(c, 16'($random(seed)));
        foreach (expv[c]) rdx(c, expv[c]);
        @(negedge clk) padIn = 16'($random(seed));
        rdx(8'hE5, padIn);
        foreach (pv[i]) @(negedge clk) {adcValid, adcKind, adcData} = {3'h5, pv[i]};
        @(negedge clk) adcValid = 1'h0;
        foreach (pv[i]) m = (pv[i] > m) ? pv[i] : m;
        rdx(8'hDD, m);
        rdx(8'hDA, 16'h1);
        host.xfer(adr, 8'hE3, 16'h0, 2, rd);
        rdx(8'hDD, 16'h0);
        rdx(8'hBF, 16'h0);
        wr(8'hBD, 16'h1);
        foreach (pv[i]) wr(8'hBF, pv[i]);
        wr(8'hBD, 16'h1);
        foreach (pv[i]) rdx(8'hBF, pv[i]);
        wr(8'hBE, 16'h1);
        rdx(8'hBF, 16'hFFFF);
        @(negedge clk) otFault = 1'h1;
        @(negedge clk) chk({8'h0, otAction}, 16'hC0);
        wr(8'hDC, 16'h2);
        @(negedge clk) chanOff = 2'h1;
        @(negedge clk) chanOff = 2'h0;
        while (enHoldLow[0] === 1'h1 && n < 100) @(negedge clk) n++;
        chk(16'(n >= 20 && n <= 31), 16'h1);
        wr(8'hDB, 16'h1);
        @(negedge clk) retryReq = 2'h1;
        @(negedge clk) retryReq = 2'h0;
        n = 0;
        while (retryGo[0] !== 1'h1 && n < 100) @(negedge clk) n++;
        chk(16'(n >= 10 && n <= 22), 16'h1);
        @(negedge clk) chk(16'(retryGo[0]), 16'h0);
        // masked faults drive the pad, unmasked ones leave it released
        foreach (pv[i])
        begin
            @(negedge clk) faultBits[0] = i[0] ? ~expv[8'hD2] : 16'($random(seed));
            @(negedge clk) chk(16'(gpioOe[0]), 16'(|(faultBits[0] & expv[8'hD2])));
        end
        host.xfer(8'h20, 8'hB4, 16'h1234, 4, rd);
        rdx(8'hB4, expv[8'hB4]);
        host.xfer(adr, 8'h15, 16'h0, 2, rd);
        m = expv[8'hB4];
        wr(8'hB4, ~m);
        rdx(8'hB4, ~m);
        host.xfer(adr, 8'h16, 16'h0, 2, rd);
        rdx(8'hB4, m);
        stop_test();
    end
endmodule
